/* tb/cdf_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cdf_far_model #(
   parameter int H0 = 20,
   parameter int H1 = 24,
   parameter int HX = 28,
   parameter int HF = 8
) (
   input  wire logic        clk_i,
   input  wire logic        send_i,
   input  wire logic [12:0] word_i,
   output logic             busy_o,
   output logic             ref0_o,
   output logic             ref1_o,
   output logic             xtal_o,
   output logic             fclk_o,
   output logic             fdat_o
);
   int          c0;
   int          c1;
   int          cx;
   int          ph;
   int          nb;
   logic [12:0] sh;
   initial begin
      {busy_o, ref0_o, ref1_o, xtal_o, fclk_o, fdat_o} = 6'h01;
      c0 = 0;
      c1 = 0;
      cx = 0;
      ph = 0;
      nb = 0;
      sh = 13'h0000;
   end
   always @(posedge clk_i) begin
      c0 <= (c0 == H0 - 1) ? 0 : c0 + 1;
      c1 <= (c1 == H1 - 1) ? 0 : c1 + 1;
      cx <= (cx == HX - 1) ? 0 : cx + 1;
      if (c0 == H0 - 1) ref0_o <= ~ref0_o;
      if (c1 == H1 - 1) ref1_o <= ~ref1_o;
      if (cx == HX - 1) xtal_o <= ~xtal_o;
      if (send_i && !busy_o) begin
         busy_o <= 1'b1;
         fdat_o <= word_i[12];
         sh <= word_i << 1;
         nb <= 0;
         ph <= 0;
      end else if (busy_o) begin
         // Eight clk per phase keeps the shift rate well under the limit
         ph <= (ph == HF - 1) ? 0 : ph + 1;
         if (ph == HF - 1) begin
            fclk_o <= ~fclk_o;
            if (fclk_o && nb == 12) begin
               busy_o <= 1'b0;
               fdat_o <= 1'b1; // Pull-up once released
            end else if (fclk_o) begin
               fdat_o <= sh[12];
               sh <= sh << 1;
               nb <= nb + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* tb/cdf_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cdf_top_props
   import cdf_pkg::*;
(
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rstn_i,
   // Bus
   input wire logic       psel_i,
   input wire logic       penable_i,
   input wire logic       pready_o,
   input wire logic       pslverr_o,
   // Clock pins
   input wire logic [3:0] bank_a_clock_o,
   input wire logic [3:0] bank_b_clock_o,
   input wire logic [3:0] bank_c_clock_o,
   input wire logic       loop_feedback_clock_o,
   input wire logic       coincidence_n_o,
   input wire logic       clock_outputs_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic [1:0] ac_q;
   logic       rise_ac;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ac_q <= 2'h0;
      end else begin
         ac_q <= {bank_a_clock_o[0], bank_c_clock_o[0]};
      end
   end
   assign rise_ac = bank_a_clock_o[0] & bank_c_clock_o[0] & ~ac_q[1] & ~ac_q[0];
   sequence s_wait;
      psel_i && penable_i && !pready_o;
   endsequence
   // Oe must hold a cycle past the pulse, else internal reset forced it high
   sequence s_sync_end;
      $rose(coincidence_n_o) && clock_outputs_oe_o ##1 clock_outputs_oe_o;
   endsequence
   AST_ONE_WAIT: assert property (s_wait |=> pready_o)
      else $error("pready late");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("pready held");
   AST_ERR_READY: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   AST_HIZ_LOW: assert property (
      !clock_outputs_oe_o [*3] |-> coincidence_n_o && ({bank_a_clock_o, bank_b_clock_o,
      bank_c_clock_o, loop_feedback_clock_o} == 13'h0000))
      else $error("clocks run while disabled");
   AST_SYNC_EDGE: assert property (
      s_sync_end |-> ($past(rise_ac, 2) || $past(rise_ac) || rise_ac) or (##1 rise_ac))
      else $error("coincidence pulse without shared edge");
   AST_UNFREEZE_PHASE: assert property (
      $rose(bank_a_clock_o[1]) |-> $rose(bank_a_clock_o[0]))
      else $error("bank a output out of phase");
   AST_FREEZE_LOW: assert property (
      $fell(bank_a_clock_o[1]) |-> $fell(bank_a_clock_o[0]))
      else $error("shortened pulse");
   AST_BANK_EQUAL: assert property (
      clock_outputs_oe_o |-> bank_b_clock_o[0] == bank_b_clock_o[1])
      else $error("bank b outputs differ");
endmodule
bind cdf_top cdf_top_props u_props (
   .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .bank_a_clock_o(bank_a_clock_o),
   .bank_b_clock_o(bank_b_clock_o), .bank_c_clock_o(bank_c_clock_o),
   .loop_feedback_clock_o(loop_feedback_clock_o), .coincidence_n_o(coincidence_n_o),
   .clock_outputs_oe_o(clock_outputs_oe_o)
);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import cdf_pkg::*;
;
   localparam int RP0 = 40;
   localparam int RP1 = 48;
   localparam int RPX = 56;
   logic        clk, rstn, psel, pen, pwr, pe, perr, pr, oe, cn, fb;
   logic        busy, send, r0, r1, xt, fc, fd;
   logic [11:0] pa;
   logic [31:0] pw, prd, rd;
   logic [3:0]  qa, qb, qc;
   logic [12:0] obs, word;
   int          bad_count, n_tests, p, i, k;
   int          da[4] = '{4, 6, 8, 12};
   int          db[4] = '{4, 6, 8, 10};
   int          dc[4] = '{2, 4, 6, 8};
   int          df[8] = '{4, 6, 8, 10, 8, 12, 16, 20};
   assign obs = {fb, qc, qb, qa};
   cdf_top u_dut (.clk_i(clk), .rstn_i(rstn), .paddr_i(pa), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .pwdata_i(pw), .pstrb_i(4'hF), .prdata_o(prd), .pready_o(pr),
      .pslverr_o(pe), .first_reference_input_i(r0), .second_reference_input_i(r1),
      .crystal_reference_i(xt), .freeze_clock_i(fc), .freeze_data_i(fd),
      .bank_a_clock_o(qa), .bank_b_clock_o(qb), .bank_c_clock_o(qc),
      .loop_feedback_clock_o(fb), .coincidence_n_o(cn), .clock_outputs_oe_o(oe));
   cdf_far_model #(.H0(RP0 / 2), .H1(RP1 / 2), .HX(RPX / 2), .HF(8)) u_far (.clk_i(clk),
      .send_i(send), .word_i(word), .busy_o(busy), .ref0_o(r0), .ref1_o(r1), .xtal_o(xt),
      .fclk_o(fc), .fdat_o(fd));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Pready and data are taken at the edge the slave samples them
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      pa <= a;
      pwr <= w;
      pw <= d;
      psel <= 1'b1;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pr !== 1'b1 && n < 9);
      rd = prd;
      perr = pe;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 9) chk("pready", 1, 0);
   endtask
   task automatic period(input int s);
      logic prev;
      int   n;
      n = 0;
      repeat (2) begin
         p = 0;
         do begin
            prev = obs[s];
            @(negedge clk);
            p++;
            n++;
         end while (!(obs[s] === 1'b1 && prev === 1'b0) && n < 6000);
      end
   endtask
   task automatic frz(input logic [12:0] w);
      @(posedge clk);
      word <= w;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      do @(posedge clk); while (busy === 1'b1);
      k = 0;
      do begin
         apb(ADDR_FREEZE, 0, 0);
         k++;
      end while (rd !== {3'h0, w, 3'h0, w} && k < 100);
      chk("freeze word", {3'h0, w, 3'h0, w}, rd);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      final_report();
   end
   initial begin
      {rstn, psel, pen, pwr, send} = 5'h00;
      pa = 12'h000;
      pw = 32'h0000_0000;
      word = 13'h0000;
      bad_count = 0;
      n_tests = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apb(ADDR_CTRL, 0, 0);
      chk("ctrl reset", 32'h0000_7FFF, rd);
      apb(ADDR_FREEZE, 1, 32'h0000_1FFF);
      apb(ADDR_FREEZE, 0, 0);
      chk("freeze reset", 32'h0000_0000, rd);
      apb(12'h00C, 0, 0);
      chk("unmapped err", 1, perr);
      chk("unmapped data", 0, rd);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         apb(ADDR_CTRL, 1, 32'h2200 | (i << 6) | ((i % 4) * 32'h15));
         period(0);
         chk("bank a", da[i % 4] * RP0, p);
         period(4);
         chk("bank b", db[i % 4] * RP0, p);
         period(8);
         chk("bank c", dc[i % 4] * RP0, p);
         period(12);
         chk("feedback", df[i] * RP0, p);
      end
      $display("test dividers done");
      apb(ADDR_CTRL, 1, 32'h2000);
      period(8);
      chk("halving", 4 * RP0, p);
      apb(ADDR_CTRL, 1, 32'h2A00);
      period(8);
      chk("second ref", 2 * RP1, p);
      apb(ADDR_CTRL, 1, 32'h2600);
      period(8);
      chk("crystal ref", 2 * RPX, p);
      apb(ADDR_CTRL, 1, 32'h3200);
      repeat (800) @(posedge clk);
      period(12);
      chk("loop feedback", RP0, p);
      period(0);
      chk("loop bank a", RP0, p);
      $display("test paths done");
      apb(ADDR_CTRL, 1, 32'h6200);
      repeat (2) @(posedge clk);
      k = 0;
      repeat (300) begin
         @(negedge clk);
         if (qc[2] !== ~qc[0] || qc[3] !== ~qc[0] || qc[1] !== qc[0]) k++;
      end
      chk("invert", 0, k);
      $display("test invert done");
      apb(ADDR_CTRL, 1, 32'h0200);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("oe off", 0, oe);
      chk("pins off", {1'b1, 13'h0000}, {cn, obs});
      apb(ADDR_CTRL, 1, 32'h2200);
      repeat (2) @(negedge clk);
      chk("oe on", 1, oe);
      $display("test disable done");
      frz(13'h1842);
      k = 0;
      repeat (400) begin
         @(negedge clk);
         if (qa[1] !== 1'b0 || qb[2] !== 1'b0 || qc[3] !== 1'b0 || fb !== 1'b0) k++;
      end
      chk("frozen low", 0, k);
      period(0);
      chk("still running", 4 * RP0, p);
      frz(13'h0000);
      period(1);
      chk("resumed", 4 * RP0, p);
      $display("test freeze done");
      final_report();
   end
endmodule
`default_nettype wire

/* verilog/cdf_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module cdf_divider
   import cdf_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   // Control
   input  wire logic              align_i,
   input  wire logic              tick_i,
   input  wire logic [HALF_W-1:0] half_i,
   // Divided clock
   output logic                   clk_o,
   output logic                   rise_next_o
);

   logic [HALF_W-1:0] cnt_q;
   logic              clk_q;
   logic              wrap;

   // >= keeps a shrinking ratio from running past the end
   assign wrap = (cnt_q >= half_i - 4'h1);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= '0;
         clk_q <= 1'b0;
      end else if (align_i) begin
         // Park one tick short of the edge, so all banks rise together
         cnt_q <= half_i - 4'h1;
         clk_q <= 1'b0;
      end else if (tick_i) begin
         if (wrap) begin
            cnt_q <= '0;
            clk_q <= ~clk_q;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   assign clk_o       = clk_q;
   assign rise_next_o = wrap & ~clk_q;

endmodule
`default_nettype wire

/* verilog/cdf_pkg.sv */
`default_nettype none
package cdf_pkg;

   // ------------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W       = 12;
   localparam int unsigned DATA_W       = 32;
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_FREEZE  = 12'h004;
   localparam logic [11:0] ADDR_STATUS  = 12'h008;

   // ------------------------------------------------------------------
   // Output numbering: A 0..3, B 4..7, C 8..11, feedback 12
   // ------------------------------------------------------------------
   localparam int unsigned NUM_OUT      = 13;
   localparam int unsigned FRZ_CNT_W    = 4;
   localparam logic [3:0]  FRZ_LAST_BIT = 4'hC;
   localparam int unsigned FRZ_PEND_LSB = 16;

   // Status word layout
   localparam int unsigned PER_W          = 16;
   localparam int unsigned STAT_VALID_BIT = 16;
   localparam int unsigned STAT_COINC_BIT = 17;

   // Synchroniser lanes
   localparam int unsigned SYN_W    = 5;
   localparam int unsigned SYN_REF0 = 0;
   localparam int unsigned SYN_REF1 = 1;
   localparam int unsigned SYN_XTAL = 2;
   localparam int unsigned SYN_FCLK = 3;
   localparam int unsigned SYN_FDAT = 4;

   // Divider widths
   localparam int unsigned HALF_W = 4;
   localparam int unsigned DIV_W  = 5;
   localparam int unsigned MUL_W  = 6;
   localparam int unsigned ACC_W  = 17;

   // ------------------------------------------------------------------
   // Control word
   // ------------------------------------------------------------------
   typedef struct packed {
      logic invert_c_upper;
      logic reset_and_output_enable;
      logic loop_enable;
      logic reference_clock_pick;
      logic reference_source;
      logic oscillator_halving_select;
      logic feedback_divider_select_top;
      logic feedback_divider_select_mid;
      logic feedback_divider_select_low;
      logic bank_c_divider_select_high;
      logic bank_c_divider_select_low;
      logic bank_b_divider_select_high;
      logic bank_b_divider_select_low;
      logic bank_a_divider_select_high;
      logic bank_a_divider_select_low;
   } cdf_ctrl_type;

   localparam int unsigned  CTRL_W     = 15;
   localparam int unsigned  SEL_W      = 10;
   localparam cdf_ctrl_type CTRL_RESET = 15'h7FFF;

   // ------------------------------------------------------------------
   // Divider tables: bank entries as half periods, feedback entries as whole periods, in divider-input ticks
   // ------------------------------------------------------------------
   function automatic logic [HALF_W-1:0] bank_a_half(input logic [1:0] s);
      case (s)
         2'h0:    bank_a_half = 4'h2;
         2'h1:    bank_a_half = 4'h3;
         2'h2:    bank_a_half = 4'h4;
         default: bank_a_half = 4'h6;
      endcase
   endfunction

   function automatic logic [HALF_W-1:0] bank_b_half(input logic [1:0] s);
      case (s)
         2'h0:    bank_b_half = 4'h2;
         2'h1:    bank_b_half = 4'h3;
         2'h2:    bank_b_half = 4'h4;
         default: bank_b_half = 4'h5;
      endcase
   endfunction

   function automatic logic [HALF_W-1:0] bank_c_half(input logic [1:0] s);
      case (s)
         2'h0:    bank_c_half = 4'h1;
         2'h1:    bank_c_half = 4'h2;
         2'h2:    bank_c_half = 4'h3;
         default: bank_c_half = 4'h4;
      endcase
   endfunction

   function automatic logic [DIV_W-1:0] feedback_div(input logic [2:0] s);
      case (s)
         3'h0:    feedback_div = 5'h04;
         3'h1:    feedback_div = 5'h06;
         3'h2:    feedback_div = 5'h08;
         3'h3:    feedback_div = 5'h0A;
         3'h4:    feedback_div = 5'h08;
         3'h5:    feedback_div = 5'h0C;
         3'h6:    feedback_div = 5'h10;
         default: feedback_div = 5'h14;
      endcase
   endfunction

endpackage
`default_nettype wire

/* verilog/cdf_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Bank A divides by 4, 6, 8, 12
// - Bank B divides by 4, 6, 8, 10
// - Bank C divides by 2, 4, 6, 8
// - Feedback divides per eight-entry table
// - Feedback select independent of bank selects
// - Dividers realign automatically on select change
// - Power-on reset initialises divider state
// - Halving select low adds divide-by-two ahead
// - Reference source: single-ended or crystal
// - Reference pick: first or second input
// - Loop disabled bypasses oscillator with reference
// - Reset/enable low resets, outputs high-impedance
// - Invert third and fourth bank C outputs
// - Coincidence low one tick before shared rise
// - Serial port freezes outputs individually
// - Frozen output low, dividers keep running
// - Unfrozen output resumes in phase
// - Freeze changes only while output low
// - Power-up clears all freeze state
// - Twelve clocks, feedback and coincidence outputs
// - Three banks of four outputs
module cdf_top
   import cdf_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [DATA_W-1:0] pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output logic      [DATA_W-1:0] prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Reference pins
   input  wire logic              first_reference_input_i,
   input  wire logic              second_reference_input_i,
   input  wire logic              crystal_reference_i,
   // Serial freeze port
   input  wire logic              freeze_clock_i,
   input  wire logic              freeze_data_i,
   // Clock outputs
   output logic      [3:0]        bank_a_clock_o,
   output logic      [3:0]        bank_b_clock_o,
   output logic      [3:0]        bank_c_clock_o,
   output logic                   loop_feedback_clock_o,
   output logic                   coincidence_n_o,
   output logic                   clock_outputs_oe_o
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [SYN_W-1:0] syn1_q;
   logic [SYN_W-1:0] syn2_q;
   logic [SYN_W-1:0] syn3_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         syn1_q <= '0;
         syn2_q <= '0;
         syn3_q <= '0;
      end else begin
         syn1_q <= {freeze_data_i, freeze_clock_i, crystal_reference_i,
                    second_reference_input_i, first_reference_input_i};
         syn2_q <= syn1_q;
         syn3_q <= syn2_q;
      end
   end

   // ------------------------------------------------------------------
   // Control register and derived selections
   // ------------------------------------------------------------------
   cdf_ctrl_type      ctrl_q;
   logic [SEL_W-1:0]  sel_prev_q;
   logic [SEL_W-1:0]  sel_now;
   logic              core_run;
   logic              align;
   logic [1:0]        sel_a;
   logic [1:0]        sel_b;
   logic [1:0]        sel_c;
   logic [2:0]        sel_fb;
   logic [DIV_W-1:0]  fb_div;

   assign sel_a  = {ctrl_q.bank_a_divider_select_high, ctrl_q.bank_a_divider_select_low};
   assign sel_b  = {ctrl_q.bank_b_divider_select_high, ctrl_q.bank_b_divider_select_low};
   assign sel_c  = {ctrl_q.bank_c_divider_select_high, ctrl_q.bank_c_divider_select_low};
   assign sel_fb = {ctrl_q.feedback_divider_select_top,
                    ctrl_q.feedback_divider_select_mid,
                    ctrl_q.feedback_divider_select_low};
   assign fb_div = feedback_div(sel_fb);
   assign sel_now  = ctrl_q[SEL_W-1:0];
   assign core_run = ctrl_q.reset_and_output_enable;
   // Any select change or internal reset restarts all dividers together
   assign align = ~core_run | (sel_now != sel_prev_q);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // Mismatch forces one alignment at the first edge
         sel_prev_q <= ~CTRL_RESET[SEL_W-1:0];
      end else begin
         sel_prev_q <= sel_now;
      end
   end

   // ------------------------------------------------------------------
   // Reference selection
   // ------------------------------------------------------------------
   logic ref_cur;
   logic ref_prev;
   logic ref_rise;

   always_comb begin
      if (ctrl_q.reference_source) begin
         ref_cur  = syn2_q[SYN_XTAL];
         ref_prev = syn3_q[SYN_XTAL];
      end else if (ctrl_q.reference_clock_pick) begin
         ref_cur  = syn2_q[SYN_REF1];
         ref_prev = syn3_q[SYN_REF1];
      end else begin
         ref_cur  = syn2_q[SYN_REF0];
         ref_prev = syn3_q[SYN_REF0];
      end
   end

   assign ref_rise = ref_cur & ~ref_prev;

   // ------------------------------------------------------------------
   // Ideal oscillator: reference period measured, ticks spread evenly
   // ------------------------------------------------------------------
   logic [PER_W-1:0] per_cnt_q;
   logic [PER_W-1:0] per_q;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_sum;
   logic [MUL_W-1:0] mult;
   logic             vco_tick_q;

   // Oscillator runs twice as fast when the extra halving is in the loop
   assign mult    = ctrl_q.oscillator_halving_select ? {1'b0, fb_div}
                                                     : {fb_div, 1'b0};
   assign acc_sum = acc_q + {{(ACC_W-MUL_W){1'b0}}, mult};

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         per_cnt_q <= '0;
         per_q     <= '0;
      end else if (!core_run) begin
         per_cnt_q <= '0;
         per_q     <= '0;
      end else if (ref_rise) begin
         per_cnt_q <= '0;
         per_q     <= per_cnt_q + 16'h0001;
      end else if (per_cnt_q != {PER_W{1'b1}}) begin
         per_cnt_q <= per_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_q      <= '0;
         vco_tick_q <= 1'b0;
      end else if (align || (per_q == '0)) begin
         acc_q      <= '0;
         vco_tick_q <= 1'b0;
      end else if (acc_sum >= {1'b0, per_q}) begin
         acc_q      <= acc_sum - {1'b0, per_q};
         vco_tick_q <= 1'b1;
      end else begin
         acc_q      <= acc_sum;
         vco_tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Source selection and optional divide-by-two
   // ------------------------------------------------------------------
   logic src_tick;
   logic pre_q;
   logic div_tick;

   assign src_tick = ctrl_q.loop_enable ? vco_tick_q : ref_rise;
   assign div_tick = src_tick & (ctrl_q.oscillator_halving_select | pre_q);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre_q <= 1'b0;
      end else if (align) begin
         pre_q <= 1'b0;
      end else if (src_tick) begin
         pre_q <= ~pre_q;
      end
   end

   // ------------------------------------------------------------------
   // Bank and feedback dividers
   // ------------------------------------------------------------------
   logic a_clk;
   logic b_clk;
   logic c_clk;
   logic fb_clk;
   logic a_rise_next;
   logic c_rise_next;

   cdf_divider u_div_a (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .align_i     (align),
      .tick_i      (div_tick),
      .half_i      (bank_a_half(sel_a)),
      .clk_o       (a_clk),
      .rise_next_o (a_rise_next)
   );

   cdf_divider u_div_b (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .align_i     (align),
      .tick_i      (div_tick),
      .half_i      (bank_b_half(sel_b)),
      .clk_o       (b_clk),
      .rise_next_o ()
   );

   cdf_divider u_div_c (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .align_i     (align),
      .tick_i      (div_tick),
      .half_i      (bank_c_half(sel_c)),
      .clk_o       (c_clk),
      .rise_next_o (c_rise_next)
   );

   cdf_divider u_div_fb (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .align_i     (align),
      .tick_i      (div_tick),
      .half_i      (fb_div[DIV_W-1:1]),
      .clk_o       (fb_clk),
      .rise_next_o ()
   );

   // ------------------------------------------------------------------
   // Serial freeze port
   // ------------------------------------------------------------------
   logic                 frz_rise;
   logic [NUM_OUT-2:0]   frz_shift_q;
   logic [FRZ_CNT_W-1:0] frz_cnt_q;
   logic [NUM_OUT-1:0]   frz_pend_q;
   logic [NUM_OUT-1:0]   frz_q;

   assign frz_rise = syn2_q[SYN_FCLK] & ~syn3_q[SYN_FCLK];

   // No frame marker exists, so word boundaries count from reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         frz_shift_q <= '0;
         frz_cnt_q   <= '0;
         frz_pend_q  <= '0;
      end else if (frz_rise) begin
         if (frz_cnt_q == FRZ_LAST_BIT) begin
            frz_pend_q <= {frz_shift_q, syn2_q[SYN_FDAT]};
            frz_cnt_q  <= '0;
         end else begin
            frz_shift_q <= {frz_shift_q[NUM_OUT-3:0], syn2_q[SYN_FDAT]};
            frz_cnt_q   <= frz_cnt_q + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------------
   logic [NUM_OUT-1:0] raw;
   logic [NUM_OUT-1:0] out_q;
   logic               coinc_n_q;
   logic               oe_q;

   assign raw = {fb_clk,
                 {2{c_clk ^ ctrl_q.invert_c_upper}}, {2{c_clk}},
                 {4{b_clk}}, {4{a_clk}}};

   // Freeze only latches while both the pin and its source are low
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         frz_q <= '0;
      end else begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (!out_q[i] && !raw[i]) begin
               frz_q[i] <= frz_pend_q[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_q <= '0;
      end else begin
         out_q <= raw & ~frz_q;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         coinc_n_q <= 1'b1;
         oe_q      <= 1'b0;
      end else begin
         coinc_n_q <= ~(core_run & a_rise_next & c_rise_next);
         oe_q      <= core_run;
      end
   end

   assign bank_a_clock_o        = out_q[3:0];
   assign bank_b_clock_o        = out_q[7:4];
   assign bank_c_clock_o        = out_q[11:8];
   assign loop_feedback_clock_o = out_q[NUM_OUT-1];
   assign coincidence_n_o       = coinc_n_q;
   assign clock_outputs_oe_o    = oe_q;

   // ------------------------------------------------------------------
   // APB slave, one wait state
   // ------------------------------------------------------------------
   logic              pready_q;
   logic              pslverr_q;
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] rd_data;
   logic              rd_hit;
   logic              apb_access;
   logic              apb_done;

   assign apb_access = psel_i & penable_i;
   assign apb_done   = apb_access & pready_q;

   always_comb begin
      rd_data = '0;
      rd_hit  = 1'b1;
      case (paddr_i)
         ADDR_CTRL: begin
            rd_data[CTRL_W-1:0] = ctrl_q;
         end
         ADDR_FREEZE: begin
            rd_data[NUM_OUT-1:0]                         = frz_q;
            rd_data[FRZ_PEND_LSB +: NUM_OUT]             = frz_pend_q;
         end
         ADDR_STATUS: begin
            rd_data[PER_W-1:0]     = per_q;
            rd_data[STAT_VALID_BIT] = (per_q != '0);
            rd_data[STAT_COINC_BIT] = coinc_n_q;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else if (apb_access && !pready_q) begin
         pready_q  <= 1'b1;
         pslverr_q <= ~rd_hit;
         prdata_q  <= pwrite_i ? '0 : rd_data;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (apb_done && pwrite_i && (paddr_i == ADDR_CTRL)) begin
         if (pstrb_i[0]) begin
            ctrl_q[7:0] <= pwdata_i[7:0];
         end
         if (pstrb_i[1]) begin
            ctrl_q[CTRL_W-1:8] <= pwdata_i[CTRL_W-1:8];
         end
      end
   end

   assign prdata_o  = prdata_q;
   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;

endmodule
`default_nettype wire
